// ==== dv/hbd_host.sv ====
// serial host model that drives frames into the control port
// assumes: clock idles low and runs only inside frames; serial output line floats when released
module hbd_host (
  output logic      chip_select_n,
  output logic      link_clk,
  output logic      serial_in,
  input  wire logic serial_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    chip_select_n = 1'h1;
    link_clk      = 1'h0;
    serial_in     = 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // sends nbits msb first at 160 ns; got collects the bits seen after each rise
  task automatic frame(input int nbits, input logic [31:0] data, output logic [31:0] got, output logic pre);
    got = 32'h0;
    #7 chip_select_n = 1'h0;
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_in = data[i];
      #40;
      if (i == nbits - 1) pre = serial_out;
      link_clk = 1'h1;
      #80;
      got = {got[30:0], serial_out};
      link_clk = 1'h0;
      #40;
    end
    serial_in = 1'h0;
    chip_select_n = 1'h1;
    #5000;
  endtask
endmodule

// ==== dv/testbench.sv ====
// self-checking bench for the half-bridge driver serial control port
// assumes: design package, design and host model are compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     sys_clk = 1'h0;
  logic                     rst = 1'h1;
  logic                     enable = 1'h0;
  logic                     supply_fault = 1'h0;
  logic                     thermal_warning = 1'h0;
  logic [11:0]              bridge_status = 12'h000;
  hbd_pkg::fault_event_type fault_event = 3'h0;
  hbd_pkg::command_type     command;
  logic                     chip_select_n, link_clk, serial_in, serial_out, serial_out_oe_n;
  logic                     drivers_on, sleep_mode, frame_error, thermal_shutdown_flag;
  int                       fe_count = 0;
  logic [31:0]              got;
  logic                     pre;
  int                       err_total = 0;
  int                       checks_done = 0;
  // the pin floats whenever the port lets go of it
  wire so_line = serial_out_oe_n ? 1'hz : serial_out;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (frame_error === 1'h1) fe_count <= fe_count + 1;
  half_bridge_driver_spi_slave u_half_bridge_driver_spi_slave (.sys_clk, .rst, .enable, .chip_select_n,
    .link_clk, .serial_in, .serial_out, .serial_out_oe_n, .fault_event, .supply_fault, .thermal_warning,
    .bridge_status, .command, .drivers_on, .sleep_mode, .frame_error, .thermal_shutdown_flag);
  hbd_host u_hbd_host (.chip_select_n, .link_clk, .serial_in, .serial_out(so_line));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("sleep", 1'h1, sleep_mode);
    chk("command", 16'h0, command);
    chk("oe_n", 1'h1, serial_out_oe_n);
    enable = 1'h1;
    cyc(20);
    chk("drivers", 1'h1, drivers_on);
    #100000;
    $display("test reset done");
  endtask
  task automatic t_word;
    supply_fault = 1'h1;
    thermal_warning = 1'h1;
    bridge_status = 12'h5a3;
    cyc(5);
    u_hbd_host.frame(16, 32'h2abc, got, pre);
    chk("status", 32'h4b47, got);
    chk("pre", 1'h0, pre);
    chk("oe_n", 1'h1, serial_out_oe_n);
    cyc(10);
    chk("command", 16'h2abc, command);
    $display("test word done");
  endtask
  task automatic t_error;
    int fe_before;
    fe_before = fe_count;
    u_hbd_host.frame(12, 32'h0fff, got, pre);
    cyc(10);
    chk("error", 32'h1, fe_count - fe_before);
    chk("kept", 16'h2abc, command);
    fe_before = fe_count;
    u_hbd_host.frame(24, 32'hab1555, got, pre);
    cyc(10);
    chk("no error", 32'h0, fe_count - fe_before);
    chk("command", 16'h1555, command);
    $display("test error done");
  endtask
  task automatic t_faults;
    fault_event = 3'h7;
    cyc(1);
    fault_event = 3'h0;
    cyc(5);
    chk("tsd", 1'h1, thermal_shutdown_flag);
    u_hbd_host.frame(16, 32'h8000, got, pre);
    chk("pre", 1'h1, pre);
    chk("ovc", 1'h1, got[15]);
    chk("uld", 1'h1, got[13]);
    cyc(10);
    chk("tsd clr", 1'h0, thermal_shutdown_flag);
    u_hbd_host.frame(16, 32'h0a5a, got, pre);
    chk("pre clr", 1'h0, pre);
    chk("ovc clr", 1'h0, got[15]);
    chk("uld clr", 1'h0, got[13]);
    cyc(10);
    chk("command", 16'h0a5a, command);
    $display("test faults done");
  endtask
  task automatic t_off;
    fault_event = 3'h2;
    cyc(1);
    fault_event = 3'h0;
    cyc(5);
    chk("tsd set", 1'h1, thermal_shutdown_flag);
    enable = 1'h0;
    cyc(10);
    chk("tsd off", 1'h0, thermal_shutdown_flag);
    chk("command", 16'h0, command);
    chk("drivers", 1'h0, drivers_on);
    chk("sleep", 1'h1, sleep_mode);
    u_hbd_host.frame(16, 32'h1234, got, pre);
    chk("float", 32'h0000zzzz, got);
    cyc(10);
    chk("ignored", 16'h0, command);
    $display("test off done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(5);
    rst = 1'h0;
    t_reset;
    t_word;
    t_error;
    t_faults;
    t_off;
    print_verdict;
  end
  // about four times the expected run length
  initial begin
    #600000;
    err_total++;
    print_verdict;
  end
endmodule

// ==== hw/half_bridge_driver_spi_slave.sv ====
// serial control port of a six-channel half-bridge driver
// assumes: link_clk is the host serial clock, idle low and stopped
// outside frames; fault events come from logic on sys_clk
`include "hbd_regs.svh"

module half_bridge_driver_spi_slave (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     enable,
  input  wire logic                     chip_select_n,
  input  wire logic                     link_clk,
  input  wire logic                     serial_in,
  output logic                          serial_out,
  output logic                          serial_out_oe_n,
  input  wire hbd_pkg::fault_event_type fault_event,
  input  wire logic                     supply_fault,
  input  wire logic                     thermal_warning,
  input  wire logic [11:0]              bridge_status,
  output hbd_pkg::command_type          command,
  output logic                          drivers_on,
  output logic                          sleep_mode,
  output logic                          frame_error,
  output logic                          thermal_shutdown_flag
);

  ////////////////////////////////////////////////////////////////////
  // declarations

  logic                 en_s1;
  logic                 en_s2;
  logic                 cs_s1;
  logic                 cs_s2;
  logic                 cs_hold;
  hbd_pkg::mode_type    mode;
  hbd_pkg::mode_type    next_mode;
  logic [2:0]           por_cnt;
  logic                 ocs_flag;
  logic                 uld_flag;
  logic                 tsd_flag;
  hbd_pkg::status_type  status_snap;
  logic                 tsd_snap;
  logic                 clocked;
  logic [4:0]           link_cnt;
  logic [15:0]          rx_word;
  logic [14:0]          tx_word;
  logic                 so_bit;

  ////////////////////////////////////////////////////////////////////
  // helpers

  // a latched fault: a new event wins over a clear in the same cycle
  function automatic logic latch_next(
    input logic flag,
    input logic set,
    input logic clear,
    input logic keep
  );
    latch_next = keep & (set | (flag & ~clear));
  endfunction

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      en_s1   <= 1'b0;
      en_s2   <= 1'b0;
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
      cs_hold <= 1'b1;
    end else begin
      en_s1   <= enable;
      en_s2   <= en_s1;
      cs_s1   <= chip_select_n;
      cs_s2   <= cs_s1;
      cs_hold <= cs_s2;
    end
  end

  // cs_hold also clears the link side; it drops about 30 ns after
  // select falls, well inside the host's select setup time
  wire frame_end = cs_s2 & ~cs_hold;

  ////////////////////////////////////////////////////////////////////
  // enable, power-on and sleep

  wire run      = (mode == hbd_pkg::RUN);
  wire last_por = (por_cnt == `POR_LAST);
  // enable low acts at the edge where it is seen, not one edge later
  wire live     = run & en_s2;

  always_comb begin
    next_mode = mode;
    unique case (mode)
      hbd_pkg::SLEEP: begin
        if (en_s2) begin
          next_mode = hbd_pkg::POWER_ON;
        end
      end
      hbd_pkg::POWER_ON: begin
        if (last_por) begin
          next_mode = hbd_pkg::RUN;
        end
      end
      hbd_pkg::RUN: begin
        next_mode = hbd_pkg::RUN;
      end
      default: begin
        next_mode = hbd_pkg::SLEEP;
      end
    endcase
    if (!en_s2) begin
      next_mode = hbd_pkg::SLEEP;
    end
  end

  wire [2:0] next_por = (mode == hbd_pkg::POWER_ON) ? por_cnt + `POR_STEP : `POR_FIRST;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode       <= hbd_pkg::SLEEP;
      por_cnt    <= `POR_FIRST;
      drivers_on <= 1'b0;
      sleep_mode <= 1'b1;
    end else begin
      mode       <= next_mode;
      por_cnt    <= next_por;
      drivers_on <= (next_mode == hbd_pkg::RUN);
      sleep_mode <= (next_mode == hbd_pkg::SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // frame acceptance and command register

  // link registers are quiet here: the serial clock has stopped and
  // select has been high for two sys_clk cycles
  wire cnt_mod8  = (link_cnt[`CNT_MOD8_MSB:0] == `CNT_MOD8_ZERO);
  wire shape_ok  = clocked & link_cnt[`CNT_GE16_BIT] & cnt_mod8;
  wire frame_ok  = frame_end & live & shape_ok;
  wire frame_bad = frame_end & live & ~shape_ok;
  wire srr_seen  = frame_ok & rx_word[`CMD_SRR_BIT];

  wire [15:0] next_cmd = !live ? `WORD_ZERO : (frame_ok ? rx_word : command);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      command     <= `WORD_ZERO;
      frame_error <= 1'b0;
    end else begin
      command     <= next_cmd;
      frame_error <= frame_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // latched faults

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ocs_flag <= 1'b0;
      uld_flag <= 1'b0;
      tsd_flag <= 1'b0;
    end else begin
      ocs_flag <= latch_next(ocs_flag, fault_event.overcurrent, srr_seen, live);
      uld_flag <= latch_next(uld_flag, fault_event.underload, srr_seen, live);
      tsd_flag <= latch_next(tsd_flag, fault_event.thermal_shutdown, srr_seen, live);
    end
  end

  assign thermal_shutdown_flag = tsd_flag;

  ////////////////////////////////////////////////////////////////////
  // status snapshot for the link

  // frozen while select is low so the shifter sees one coherent word;
  // a fault arising mid-frame shows in the next frame
  wire [15:0] status_now = {ocs_flag, supply_fault & run, uld_flag, bridge_status & {12{run}},
                            thermal_warning & run};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_snap <= `WORD_ZERO;
      tsd_snap    <= 1'b0;
    end else if (cs_s2) begin
      status_snap <= status_now;
      tsd_snap    <= tsd_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // link domain

  always_ff @(posedge link_clk or posedge cs_hold) begin
    if (cs_hold) begin
      clocked <= 1'b0;
    end else begin
      clocked <= 1'b1;
    end
  end

  // mod 16 until sixteen edges, then mod 8
  wire [4:0] next_cnt = !clocked ? `CNT_FIRST :
                        (link_cnt == `CNT_WRAP) ? `CNT_REWIND : link_cnt + `CNT_STEP;

  wire        next_so = clocked ? tx_word[`TX_MSB] : status_snap[`STAT_MSB];
  wire [14:0] next_tx = clocked ? {tx_word[`TX_MSB-1:0], rx_word[0]} : status_snap[`TX_MSB:0];

  always_ff @(posedge link_clk) begin
    link_cnt <= next_cnt;
    so_bit   <= next_so;
    tx_word  <= next_tx;
  end

  // data is taken on the falling edge, three quarters of a period after the host
  // changes it and a quarter of a period before its next change
  always_ff @(negedge link_clk) begin
    rx_word <= {rx_word[14:0], serial_in};
  end

  ////////////////////////////////////////////////////////////////////
  // serial output pin

  assign serial_out      = clocked ? so_bit : tsd_snap;
  assign serial_out_oe_n = chip_select_n | ~drivers_on;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_load_valid: assert property (
    frame_ok |=> command == $past(rx_word)
  ) else $error("accepted frame not loaded");

  a_reject_keep: assert property (
    frame_bad |=> frame_error && $stable(command)
  ) else $error("bad frame changed command or no error");

  a_srr_clear: assert property (
    srr_seen && !fault_event.overcurrent && en_s2 |=> !ocs_flag
  ) else $error("status reset did not clear overcurrent");

  a_event_wins: assert property (
    run && en_s2 && fault_event.overcurrent |=> ocs_flag
  ) else $error("overcurrent event lost");

  a_sleep_clear: assert property (
    !en_s2 |=> command == `WORD_ZERO && mode == hbd_pkg::SLEEP && !tsd_flag
  ) else $error("enable low did not clear");

  a_drivers_off: assert property (
    !en_s2 |=> !drivers_on && sleep_mode && serial_out_oe_n
  ) else $error("drivers or output active while disabled");

  a_por_run: assert property (
    mode == hbd_pkg::SLEEP && en_s2 ##1 en_s2 [*8] |=> mode == hbd_pkg::RUN && drivers_on
  ) else $error("power-on sequence length wrong");

  a_cmd_reset: assert property (
    $rose(mode == hbd_pkg::RUN) |-> command == `WORD_ZERO && $past(mode) == hbd_pkg::POWER_ON
  ) else $error("command not zero after power-on");

  a_cmd_hold: assert property (
    live && !frame_ok |=> $stable(command)
  ) else $error("command changed without a frame");

  a_err_quiet: assert property (
    frame_ok |=> !frame_error
  ) else $error("error flagged on a good frame");

  a_error_pulse: assert property (
    frame_error |=> !frame_error
  ) else $error("frame error longer than one cycle");

  a_idle_cmd: assert property (
    !run |=> command == `WORD_ZERO
  ) else $error("command set outside normal operation");

  a_uld_clear: assert property (
    srr_seen && !fault_event.underload |=> !uld_flag
  ) else $error("status reset did not clear underload");

  a_tsd_clear: assert property (
    srr_seen && !fault_event.thermal_shutdown |=> !tsd_flag
  ) else $error("status reset did not clear thermal flag");

  a_tsd_wins: assert property (
    live && fault_event.thermal_shutdown |=> tsd_flag
  ) else $error("thermal event lost");

  a_snap_track: assert property (
    cs_s2 |=> status_snap == $past(status_now)
  ) else $error("status snapshot not following status");

  a_snap_frozen: assert property (
    !cs_s2 |=> $stable(status_snap)
  ) else $error("status snapshot moved inside a frame");

  a_pre_frozen: assert property (
    !cs_s2 |=> $stable(tsd_snap)
  ) else $error("thermal snapshot moved inside a frame");

endmodule

// ==== hw/hbd_pkg.sv ====
// types shared by the half-bridge driver serial control port
// assumes: nothing beyond a SystemVerilog elaborator
package hbd_pkg;

  typedef struct packed {
    logic       status_reset_request;
    logic       group_select;
    logic       underload_shutdown;
    logic [5:0] bridge_enable;
    logic [5:0] bridge_config;
    logic       overvoltage_lockout;
  } command_type;

  typedef struct packed {
    logic        latched_overcurrent_flag;
    logic        supply_fault;
    logic        underload;
    logic [11:0] bridge_status;
    logic        thermal_warning;
  } status_type;

  typedef struct packed {
    logic overcurrent;
    logic thermal_shutdown;
    logic underload;
  } fault_event_type;

  typedef enum logic [1:0] {
    SLEEP    = 2'b00,
    POWER_ON = 2'b01,
    RUN      = 2'b10
  } mode_type;

endpackage

// ==== hw/hbd_regs.svh ====
// constants for the half-bridge driver serial control port
// assumes: included by its bare name; the types live in hbd_pkg
//
// Overview of operation
// - frames are full-duplex exchanges of 16 bits or more
// - select low shows thermal flag before first clock
// - data enters msb first, request bit leading
// - status leaves msb first, overcurrent flag leading
// - select high ends frame, output floats
// - load last 16 bits only without error
// - port works only while enable is high
// - enable low clears registers, drivers off, sleep
// - enable high runs power-on sequence, then programmable
// - error unless clock count is a multiple of eight, sixteen or more
// - status reset request clears latched faults
// - command bits are zero after power-on
`ifndef HBD_REGS_SVH
`define HBD_REGS_SVH

`define WORD_BITS      16
`define CMD_SRR_BIT    15
`define STAT_MSB       15
`define TX_MSB         14
`define CNT_GE16_BIT   4
`define CNT_MOD8_MSB   2
`define CNT_FIRST      5'h01
`define CNT_STEP       5'h01
`define CNT_WRAP       5'h17
`define CNT_REWIND     5'h10
`define CNT_MOD8_ZERO  3'h0
`define POR_FIRST      3'h0
`define POR_STEP       3'h1
`define POR_LAST       3'h7
`define WORD_ZERO      16'h0000

`endif
